// [rtl/ssic_top.sv]
`timescale 1ns/100ps
`include "ssic_defs.svh"
// Behaviour
// - The added control register sits at 0C0H and every bit except the flag bits 1 and 5 in level mode can be set or cleared alone.
// - A bit set aimed at address 0C2H sets the interrupt-2 enable.
// - Each added interrupt goes to the high level when its priority bit is set, else low.
// - An added interrupt is taken only while its enable bit is set.
// - Trigger bit set means falling edge, clear means low level, on the pin.
// - In edge mode the flag is set on the edge and cleared when the core vectors to it.
// - Interrupts 2 and 3 come from port bits 2 and 3 when in alternate use.
// - Seven sources in two levels, each placed by its own priority bit.
// - Within one level the order is ext0, tmr0, ext1, tmr1, serial, ext2, ext3.
// - Vectors are 03H, 0BH, 13H, 1BH, 23H, 33H, 3BH in that order.
// - Enable bits 0..4 gate the standard sources; timer-control bits 0 and 2 pick trigger.
// - The idle bit stops the core clock; any enabled interrupt not blocked by a routine in progress, or reset, ends idle.
// - The power-down bit stops all clocks; only reset ends it.
// - Reset clears the interrupt control registers to zero.
module ssic_top (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Core register access and handshake
   input wire ssic_pkg::ssic_sfr_req_type sfr,
   input wire logic vec_ack,
   input wire logic reti,
   input wire logic [2:0] std_flags,
   // Pins
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   input wire logic [3:0] nibble_port,
   input wire logic [1:0] alt_fn_en,
   // Results
   output ssic_pkg::ssic_vec_type vec,
   output logic [7:0] ext_irq_ctl,
   output logic core_clk_en,
   output logic osc_run
);
   import ssic_pkg::*;
   ////////////////////////////////////////////////////////////////////
   logic [7:0] irq_enable_reg;
   logic [7:0] prio_reg;
   logic [3:0] timer_ctl_reg;
   ssic_pwr_type pwr;
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_d;
   logic [1:0] active;
   logic [1:0] lvl_stack;
   logic [6:0] pend;
   logic [6:0] prio_high;
   logic found;
   logic [2:0] pick_src;
   logic pick_high;
   logic [3:0] fall;
   logic [7:0] next_ctl;
   logic [3:0] next_timer_ctl_reg;
   logic ctl_byte_wr;
   logic ctl_bit_wr;
   logic [2:0] bit_idx;
   logic pc_wr;
   logic [3:0] lvl;
   logic clr_ext0;
   logic clr_ext1;
   logic clr_ext2;
   logic clr_ext3;
   logic take;
   logic [7:0] pick_vec;
   function automatic logic [7:0] vec_of(input logic [2:0] s);
      logic [7:0] v;
      v = `SSIC_VEC_EXT0;
      unique case (s)
         3'h0: v = `SSIC_VEC_EXT0;
         3'h1: v = `SSIC_VEC_TMR0;
         3'h2: v = `SSIC_VEC_EXT1;
         3'h3: v = `SSIC_VEC_TMR1;
         3'h4: v = `SSIC_VEC_SER;
         3'h5: v = `SSIC_VEC_EXT2;
         3'h6: v = `SSIC_VEC_EXT3;
         default: v = `SSIC_VEC_EXT0;
      endcase
      return v;
   endfunction
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers; pins are asynchronous to the clock
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_s1 <= 4'hf;
         pin_s2 <= 4'hf;
         pin_d <= 4'hf;
      end else begin
         pin_s1 <= {nibble_port[3], nibble_port[2], ext_irq1_pin, ext_irq0_pin};
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
      end
   end
   // Port bits act as general I/O unless alternate use is on
   assign lvl = {~pin_s2[3] & alt_fn_en[1], ~pin_s2[2] & alt_fn_en[0],
      ~pin_s2[1], ~pin_s2[0]};
   assign fall = pin_d & ~pin_s2 & {alt_fn_en, 2'b11};
   ////////////////////////////////////////////////////////////////////
   // Register decode
   assign ctl_byte_wr = sfr.wr && sfr.addr == `SSIC_EXT_IRQ_CTL_ADDR;
   assign ctl_bit_wr = sfr.bit_wr &&
      sfr.addr[7:3] == 5'(`SSIC_EXT_IRQ_CTL_BIT_BASE >> 3);
   assign bit_idx = sfr.addr[2:0];
   assign pc_wr = sfr.wr && sfr.addr == `SSIC_POWER_CTL_ADDR;
   assign take = found && !vec.req && pwr != SSIC_PDOWN;
   assign pick_vec = vec_of(pick_src);
   assign clr_ext0 = vec_ack && vec.src == 3'h0 && timer_ctl_reg[`SSIC_TIMER_CTL_REG_IT0];
   assign clr_ext1 = vec_ack && vec.src == 3'h2 && timer_ctl_reg[`SSIC_TIMER_CTL_REG_IT1];
   assign clr_ext2 = vec_ack && vec.src == 3'h5 && ext_irq_ctl[`SSIC_IRQ2_EDGE_SEL];
   assign clr_ext3 = vec_ack && vec.src == 3'h6 && ext_irq_ctl[`SSIC_IRQ3_EDGE_SEL];
   // Next value of the added register: write, then clear, then set wins
   always_comb begin
      next_ctl = ext_irq_ctl;
      if (ctl_byte_wr) begin
         next_ctl = sfr.wdata;
      end
      if (ctl_bit_wr) begin
         next_ctl[bit_idx] = sfr.bit_val;
      end
      if (clr_ext2) begin
         next_ctl[`SSIC_IRQ2_FLAG] = 1'b0;
      end
      if (clr_ext3) begin
         next_ctl[`SSIC_IRQ3_FLAG] = 1'b0;
      end
      // Level mode flag follows the pin; edge mode latches
      next_ctl[`SSIC_IRQ2_FLAG] = next_ctl[`SSIC_IRQ2_EDGE_SEL] ?
         (next_ctl[`SSIC_IRQ2_FLAG] | fall[2]) : lvl[2];
      next_ctl[`SSIC_IRQ3_FLAG] = next_ctl[`SSIC_IRQ3_EDGE_SEL] ?
         (next_ctl[`SSIC_IRQ3_FLAG] | fall[3]) : lvl[3];
   end
   // Standard external flags live in the timer-control copy
   always_comb begin
      next_timer_ctl_reg = timer_ctl_reg;
      if (sfr.wr && sfr.addr == `SSIC_TIMER_CTL_ADDR) begin
         next_timer_ctl_reg = sfr.wdata[3:0];
      end
      if (clr_ext0) begin
         next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE0] = 1'b0;
      end
      if (clr_ext1) begin
         next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE1] = 1'b0;
      end
      next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE0] = next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IT0] ?
         (next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE0] | fall[0]) : lvl[0];
      next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE1] = next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IT1] ?
         (next_timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE1] | fall[1]) : lvl[1];
   end
   // Gated pending set in polling order
   assign pend = {ext_irq_ctl[`SSIC_IRQ3_FLAG] & ext_irq_ctl[`SSIC_IRQ3_EN],
      ext_irq_ctl[`SSIC_IRQ2_FLAG] & ext_irq_ctl[`SSIC_IRQ2_EN],
      std_flags[2] & irq_enable_reg[4], std_flags[1] & irq_enable_reg[3],
      timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE1] & irq_enable_reg[2],
      std_flags[0] & irq_enable_reg[1],
      timer_ctl_reg[`SSIC_TIMER_CTL_REG_IE0] & irq_enable_reg[0]}
      & {7{irq_enable_reg[7]}};
   assign prio_high = {ext_irq_ctl[`SSIC_IRQ3_PRIO_HIGH], ext_irq_ctl[`SSIC_IRQ2_PRIO_HIGH],
      prio_reg[4:0]};
   ssic_prio_pick u_pick (
      .pend(pend),
      .prio_high(prio_high),
      .active(active),
      .found(found),
      .src(pick_src),
      .level_high(pick_high)
   );
   ////////////////////////////////////////////////////////////////////
   // Control registers; all clear at reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ext_irq_ctl <= `SSIC_CTL_RESET;
         irq_enable_reg <= `SSIC_CTL_RESET;
         prio_reg <= `SSIC_CTL_RESET;
         timer_ctl_reg <= 4'h0;
      end else begin
         ext_irq_ctl <= next_ctl;
         timer_ctl_reg <= next_timer_ctl_reg;
         if (sfr.wr && sfr.addr == `SSIC_IRQ_ENABLE_ADDR) begin
            irq_enable_reg <= sfr.wdata;
         end
         if (sfr.wr && sfr.addr == `SSIC_IRQ_PRIO_ADDR) begin
            prio_reg <= sfr.wdata;
         end
      end
   end
   // Vector request holds until the core acknowledges
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         vec <= '0;
         active <= 2'b00;
         lvl_stack <= 2'b00;
      end else begin
         if (take) begin
            vec <= '{req: 1'b1, vector: pick_vec, src: pick_src};
            lvl_stack <= {1'b0, pick_high};
         end else if (vec_ack) begin
            vec.req <= 1'b0;
         end
         // A return in the cycle of a new offer must not be lost
         if (vec_ack) begin
            active[lvl_stack[0]] <= 1'b1;
         end else if (reti) begin
            // Return closes the highest routine in progress
            if (active[1]) begin
               active[1] <= 1'b0;
            end else begin
               active[0] <= 1'b0;
            end
         end
      end
   end
   // Power modes: any enabled request not blocked by a routine in progress ends idle, only reset ends power-down
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pwr <= SSIC_RUN;
         core_clk_en <= 1'b1;
         osc_run <= 1'b1;
      end else begin
         if (pwr != SSIC_PDOWN && pc_wr && sfr.wdata[`SSIC_POWERDOWN_REQ_BIT]) begin
            pwr <= SSIC_PDOWN;
            core_clk_en <= 1'b0;
            osc_run <= 1'b0;
         end else if (pwr == SSIC_RUN && pc_wr && sfr.wdata[`SSIC_IDLE_REQ_BIT]) begin
            pwr <= SSIC_IDLE;
            core_clk_en <= 1'b0;
         end else if (pwr == SSIC_IDLE && found) begin
            pwr <= SSIC_RUN;
            core_clk_en <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   chk_pdown_sticky: assert property (@(posedge clock) disable iff (!nrst)
      pwr == SSIC_PDOWN |=> pwr == SSIC_PDOWN && !osc_run)
      else $error("power-down left without reset");
   chk_idle_wake: assert property (@(posedge clock) disable iff (!nrst)
      pwr == SSIC_IDLE && found |=> core_clk_en)
      else $error("idle not ended by request");
   chk_vec_map: assert property (@(posedge clock) disable iff (!nrst)
      $rose(vec.req) |-> vec.vector == {vec.src + 3'(vec.src > 3'h4), 3'h3})
      else $error("vector mismatch");
   chk_low_no_preempt: assert property (@(posedge clock) disable iff (!nrst)
      take && active != 2'b00 |-> prio_high[pick_src] && !active[1])
      else $error("low request preempted");
   chk_enable_gate: assert property (@(posedge clock) disable iff (!nrst)
      take && pick_src == 3'h5 |-> ext_irq_ctl[`SSIC_IRQ2_EN])
      else $error("disabled source taken");
   chk_edge_clear: assert property (@(posedge clock) disable iff (!nrst)
      clr_ext2 && !fall[2] && !ctl_bit_wr && !ctl_byte_wr
      |=> !ext_irq_ctl[`SSIC_IRQ2_FLAG])
      else $error("edge flag not cleared");
   chk_bit_set: assert property (@(posedge clock) disable iff (!nrst)
      sfr.bit_wr && sfr.addr == 8'hc2 && sfr.bit_val |=> ext_irq_ctl[`SSIC_IRQ2_EN])
      else $error("bit set missed");
   chk_poll_order: assert property (@(posedge clock) disable iff (!nrst)
      take && pend[0] && prio_high[0] == pick_high |-> pick_src == 3'h0)
      else $error("polling order broken");
   cov_idle_wake: cover property (@(posedge clock) disable iff (!nrst)
      pwr == SSIC_IDLE ##1 pwr == SSIC_RUN);
   cov_preempt: cover property (@(posedge clock) disable iff (!nrst)
      take && active[0]);
   cov_ext3: cover property (@(posedge clock) disable iff (!nrst)
      take && pick_src == 3'h6);
endmodule

// [rtl/ssic_defs.svh]
`ifndef SSIC_DEFS_SVH
`define SSIC_DEFS_SVH
// Special-function addresses
`define SSIC_EXT_IRQ_CTL_ADDR 8'hc0
`define SSIC_EXT_IRQ_CTL_BIT_BASE 8'hc0
`define SSIC_IRQ_ENABLE_ADDR 8'ha8
`define SSIC_IRQ_PRIO_ADDR 8'hb8
`define SSIC_TIMER_CTL_ADDR 8'h88
`define SSIC_POWER_CTL_ADDR 8'h87
// Field positions of the added control register
`define SSIC_IRQ2_EDGE_SEL 0
`define SSIC_IRQ2_FLAG 1
`define SSIC_IRQ2_EN 2
`define SSIC_IRQ2_PRIO_HIGH 3
`define SSIC_IRQ3_EDGE_SEL 4
`define SSIC_IRQ3_FLAG 5
`define SSIC_IRQ3_EN 6
`define SSIC_IRQ3_PRIO_HIGH 7
// Timer-control and power-control fields
`define SSIC_TIMER_CTL_REG_IT0 0
`define SSIC_TIMER_CTL_REG_IE0 1
`define SSIC_TIMER_CTL_REG_IT1 2
`define SSIC_TIMER_CTL_REG_IE1 3
`define SSIC_IDLE_REQ_BIT 0
`define SSIC_POWERDOWN_REQ_BIT 1
// Reset values
`define SSIC_CTL_RESET 8'h00
// Vectors in polling order
`define SSIC_VEC_EXT0 8'h03
`define SSIC_VEC_TMR0 8'h0b
`define SSIC_VEC_EXT1 8'h13
`define SSIC_VEC_TMR1 8'h1b
`define SSIC_VEC_SER 8'h23
`define SSIC_VEC_EXT2 8'h33
`define SSIC_VEC_EXT3 8'h3b
`define SSIC_NUM_SRC 7
`endif

// [rtl/ssic_pkg.sv]
package ssic_pkg;
   // Register access from the core
   typedef struct packed {
      logic wr;
      logic bit_wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic bit_val;
   } ssic_sfr_req_type;
   // Vector request to the core
   typedef struct packed {
      logic req;
      logic [7:0] vector;
      logic [2:0] src;
   } ssic_vec_type;
   typedef enum logic [1:0] {
      SSIC_RUN = 2'b00,
      SSIC_IDLE = 2'b01,
      SSIC_PDOWN = 2'b11
   } ssic_pwr_type;
endpackage

// [rtl/ssic_prio_pick.sv]
`timescale 1ns/100ps
`include "ssic_defs.svh"
// Fixed polling order inside a level, high level first
module ssic_prio_pick (
   // Requests
   input wire logic [6:0] pend,
   input wire logic [6:0] prio_high,
   input wire logic [1:0] active,
   // Choice
   output logic found,
   output logic [2:0] src,
   output logic level_high
);
   import ssic_pkg::*;
   logic [6:0] hi_req;
   logic [6:0] lo_req;
   logic hi_ok;
   logic lo_ok;
   function automatic logic [2:0] first_set(input logic [6:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 6; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction
   // Low never preempts any routine; high only preempts low
   assign hi_req = pend & prio_high;
   assign lo_req = pend & ~prio_high;
   assign hi_ok = (|hi_req) && !active[1];
   assign lo_ok = (|lo_req) && (active == 2'b00);
   assign found = hi_ok || lo_ok;
   assign level_high = hi_ok;
   assign src = hi_ok ? first_set(hi_req) : first_set(lo_req);
endmodule

// [sim/ssic_core_model.sv]
`timescale 1ns/100ps
// Core side: takes offered vectors after a chosen delay, returns after a set length
module ssic_core_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // From the controller
   input wire ssic_pkg::ssic_vec_type vec,
   // Pace of the core
   input wire logic [3:0] ack_dly,
   input wire logic [7:0] svc_len,
   // To the controller and the bench
   output logic vec_ack,
   output logic reti,
   output logic taken,
   output logic [7:0] taken_vec
);
   import ssic_pkg::*;
   logic [3:0] wait_cnt;
   logic [7:0] svc_cnt;
   logic [2:0] depth;
   ///////////////////////////////////////////////////////////
   // Ack only while a vector is offered, never twice for one offer
   wire ack_now = vec.req && !vec_ack && (wait_cnt >= ack_dly);
   // One return per taken routine; nested routines share one timer
   wire ret_now = (depth != 3'd0) && (svc_cnt >= svc_len) && !ack_now;
   ///////////////////////////////////////////////////////////
   // Handshake pulses and routine bookkeeping
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         vec_ack <= 1'b0;
         reti <= 1'b0;
         taken <= 1'b0;
         taken_vec <= 8'h00;
         wait_cnt <= 4'h0;
         svc_cnt <= 8'h00;
         depth <= 3'h0;
      end else begin
         vec_ack <= ack_now;
         taken <= ack_now;
         reti <= ret_now;
         if (ack_now) begin
            taken_vec <= vec.vector;
         end
         wait_cnt <= (vec.req && !ack_now && !vec_ack) ? wait_cnt + 4'h1 : 4'h0;
         svc_cnt <= (ack_now || ret_now) ? 8'h00 : svc_cnt + 8'h01;
         depth <= depth + 3'(ack_now) - 3'(ret_now);
      end
   end
endmodule

// [sim/seven_source_irq_ctrl_bench.sv]
`timescale 1ns/100ps
module seven_source_irq_ctrl_bench;
   import ssic_pkg::*;
   logic clock, nrst, vec_ack, reti, taken, ext_irq0_pin, ext_irq1_pin, core_clk_en, osc_run;
   logic got;
   logic [1:0] alt_fn_en;
   logic [2:0] std_flags;
   logic [3:0] nibble_port, ack_dly;
   logic [7:0] ext_irq_ctl, taken_vec, svc_len;
   ssic_sfr_req_type sfr;
   ssic_vec_type vec;
   int err_count, checks;
   ///////////////////////////////////////////////////////////
   // Controller and core model
   ssic_top dut (.clock(clock), .nrst(nrst), .sfr(sfr), .vec_ack(vec_ack), .reti(reti),
      .std_flags(std_flags), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
      .nibble_port(nibble_port), .alt_fn_en(alt_fn_en), .vec(vec), .ext_irq_ctl(ext_irq_ctl),
      .core_clk_en(core_clk_en), .osc_run(osc_run));
   ssic_core_model core (.clock(clock), .nrst(nrst), .vec(vec), .ack_dly(ack_dly),
      .svc_len(svc_len), .vec_ack(vec_ack), .reti(reti), .taken(taken), .taken_vec(taken_vec));
   // 50 ns clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   ///////////////////////////////////////////////////////////
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Byte write, or a single-bit write when bw is set; settled on return
   task wr(input logic bw, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr <= '{wr: !bw, bit_wr: bw, addr: a, wdata: d, bit_val: d[0]};
      @(posedge clock);
      sfr <= '0;
      #1;
   endtask
   // Bounded wait for the core to take a vector
   task automatic wait_taken(input int n, input logic must);
      got = 1'b0;
      for (int i = 0; i < n && !got; i++) begin
         @(posedge clock);
         got = (taken === 1'b1);
      end
      if (must && !got) begin
         err_count++;
         finish_test();
      end
   endtask
   // Reset held for two cycles, then the documented start state
   task do_reset;
      @(posedge clock);
      nrst <= 1'b0;
      tick(2);
      nrst <= 1'b1;
      @(posedge clock);
      #1;
      check({5'h0, vec.req, core_clk_en, osc_run}, 8'h03);
      check(ext_irq_ctl, 8'h00);
   endtask
   task pulse2;
      @(posedge clock);
      nibble_port[2] <= 1'b0;
      tick(2);
      nibble_port[2] <= 1'b1;
   endtask
   // First winner: enabled, high level before low, then polling order
   function automatic logic [7:0] exp_vec(logic [6:0] p, logic [6:0] e, logic [6:0] h);
      logic [6:0] r;
      r = p & e;
      if ((r & h) != 7'h0) r = r & h;
      for (int i = 0; i < 7; i++) if (r[i]) return 8'h03 + 8'(8 * (i + (i > 4)));
      return 8'h00;
   endfunction
   // One arbitration round in level mode with everything requested at once
   task automatic trial(input logic [6:0] p, input logic [6:0] e, input logic [6:0] h);
      logic [7:0] x;
      logic [7:0] c;
      x = exp_vec(p, e, h);
      c = {h[6], e[6], 2'b00, h[5], e[5], 2'b00};
      ack_dly <= 4'($urandom % 4);
      wr(1'b0, 8'ha8, {3'b100, e[4:0]});
      wr(1'b0, 8'hb8, {3'b000, h[4:0]});
      wr(1'b0, 8'hc0, c);
      check(ext_irq_ctl, c);
      ext_irq0_pin <= !p[0];
      ext_irq1_pin <= !p[2];
      nibble_port <= {!p[6], !p[5], 2'($urandom)};
      // Pins pass two flops and a flag stage; direct flags wait so all arrive together
      tick(3);
      std_flags <= {p[4], p[3], p[1]};
      wait_taken(20, x != 8'h00);
      check(got ? taken_vec : 8'h00, x);
      std_flags <= 3'b000;
      ext_irq0_pin <= 1'b1;
      ext_irq1_pin <= 1'b1;
      nibble_port <= 4'hf;
      tick(20);
   endtask
   ///////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h7ad8));
      {nrst, ext_irq0_pin, ext_irq1_pin, std_flags, alt_fn_en} = 8'h60;
      {sfr, nibble_port, ack_dly, svc_len} = {19'h0, 4'hf, 4'h0, 8'h06};
      {err_count, checks} = 0;
      do_reset();
      for (int i = 0; i < 8; i++) if (i != 1 && i != 5) begin
         wr(1'b1, 8'hc0 + 8'(i), 8'h01);
         check(ext_irq_ctl, 8'h01 << i);
         wr(1'b1, 8'hc0 + 8'(i), 8'h00);
         check(ext_irq_ctl, 8'h00);
      end
      alt_fn_en <= 2'b11;
      trial(7'h7f, 7'h7f, 7'h00);
      trial(7'h7f, 7'h7f, 7'h40);
      trial(7'h7f, 7'h1f, 7'h60);
      repeat (40) trial(7'($urandom), 7'($urandom), 7'($urandom));
      // Edge mode on the first added source, pin first kept as plain I/O
      do_reset();
      alt_fn_en <= 2'b00;
      ack_dly <= 4'hf;
      wr(1'b1, 8'hc0, 8'h01);
      wr(1'b1, 8'hc2, 8'h01);
      wr(1'b0, 8'ha8, 8'h80);
      pulse2();
      wait_taken(20, 1'b0);
      check({got, ext_irq_ctl[6:0]}, 8'h05);
      alt_fn_en <= 2'b01;
      pulse2();
      tick(6);
      #1;
      check(ext_irq_ctl, 8'h07);
      check(vec.req ? vec.vector : 8'h00, 8'h33);
      wait_taken(20, 1'b1);
      tick(2);
      #1;
      check(ext_irq_ctl, 8'h05);
      // Nesting: low waits behind low, high cuts in
      do_reset();
      {ack_dly, svc_len} <= {4'h1, 8'd100};
      alt_fn_en <= 2'b10;
      wr(1'b0, 8'ha8, 8'h92);
      wr(1'b0, 8'hc0, 8'hc0);
      std_flags <= 3'b001;
      wait_taken(20, 1'b1);
      check(taken_vec, 8'h0b);
      std_flags <= 3'b100;
      wait_taken(30, 1'b0);
      check({7'h0, got}, 8'h00);
      nibble_port[3] <= 1'b0;
      wait_taken(20, 1'b1);
      check(taken_vec, 8'h3b);
      std_flags <= 3'b000;
      nibble_port[3] <= 1'b1;
      // Idle ends on an interrupt
      do_reset();
      wr(1'b0, 8'ha8, 8'h88);
      wr(1'b0, 8'h87, 8'h01);
      tick(2);
      #1;
      check({core_clk_en, osc_run}, 8'h01);
      std_flags <= 3'b010;
      for (int i = 0; i < 10 && core_clk_en !== 1'b1; i++) @(posedge clock);
      #1;
      check({core_clk_en, osc_run}, 8'h03);
      std_flags <= 3'b000;
      // Power-down ignores interrupts, only reset ends it
      do_reset();
      wr(1'b0, 8'ha8, 8'h88);
      wr(1'b0, 8'h87, 8'h02);
      tick(2);
      std_flags <= 3'b010;
      wait_taken(20, 1'b0);
      check({got, core_clk_en, osc_run}, 8'h00);
      std_flags <= 3'b000;
      do_reset();
      finish_test();
   end
endmodule
